// *** pmsr_regs.sv ***
`timescale 1ns/1ps
module pmsr_regs
  import pmsr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Strap pins, sampled in the cycle reset is released
  input wire logic [1:0] phy_address_strap_i,
  input wire logic rmii_strap_i,
  // Management register access (from the MDIO frame engine)
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic ack_o,
  output logic [15:0] rdata_o,
  // Interrupt events, one-cycle pulses
  // Bit order: 7 jabber, 6 rx error, 5 page, 4 par fault, 3 lp ack,
  // 2 link down, 1 remote fault, 0 link up
  input wire logic [7:0] irq_event_i,
  // Mode outputs
  output logic back_to_back_o,
  output logic pin_chain_test_o,
  output logic rmii_mode_o,
  output logic energy_detect_powerdown_en_o,
  output logic [4:0] mgmt_phy_addr_o,
  output logic irq_o
);
  logic [15:0] ovr;
  logic [15:0] exp;
  logic [7:0] irq_en;
  logic [1:0] addr_strap;
  logic rmii_strap;
  logic strap_taken;
  logic [7:0] flags;
  pmsr_state_t state;
  pmsr_state_t next_state;

  // One comparator shape for every register select, so read and write decode agree
  function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] target);
    return a == target;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decode
  // The requester holds the address until ack, so it is decoded in the read
  // and write states instead of being captured when the request is taken
  wire hit_ovr = reg_hit(addr_i, ADDR_OPMODE_OVR);
  wire hit_stat = reg_hit(addr_i, ADDR_OPMODE_STAT);
  wire hit_exp = reg_hit(addr_i, ADDR_EXP_CTRL);
  wire hit_irq = reg_hit(addr_i, ADDR_IRQ_CTRL_STAT);
  wire do_wr = (state == ST_WRITE);
  wire do_rd = (state == ST_READ);
  wire wr_ovr = do_wr && hit_ovr;
  wire wr_exp = do_wr && hit_exp;
  wire wr_irq = do_wr && hit_irq;
  // The strap status register has no write path at all
  wire rd_clear = do_rd && hit_irq;

  ////////////////////////////////////////////////////////////////////////
  // Read and write data
  // Only address 0 or 3 exist: a strap of 01/10 collapses to its high bit
  wire [4:0] strap_addr = addr_strap[1] ? PHY_ADDR_HIGH : PHY_ADDR_LOW;
  wire [15:0] stat_word = (16'(addr_strap) << STAT_ADDR_LSB)
                        | (16'(rmii_strap) << STAT_RMII_BIT);
  // Flags sit in the low byte beside their enables
  wire [15:0] irq_word = {irq_en, flags};
  wire [15:0] rd_mux = hit_ovr ? ovr :
                       hit_stat ? stat_word :
                       hit_exp ? exp :
                       hit_irq ? irq_word : 16'h0000;
  // Reserved override bits above the mode field are dropped and read back as zero
  wire [15:0] ovr_wdata = wdata_i & OVR_RW_MASK;
  // Writes to the flag byte are ignored; flags only clear by being read
  wire [7:0] irq_en_wdata = wdata_i[IRQ_EN_LSB +: IRQ_NUM];

  ////////////////////////////////////////////////////////////////////////
  // Mode pin next values
  wire next_back_to_back = ovr[OVR_B2B_BIT];
  wire next_pin_chain_test = ovr[OVR_NAND_BIT];
  // Back-to-back relies on the controller also setting the RMII override;
  // the override can only force RMII on, never undo an RMII strap
  wire next_rmii_mode = ovr[OVR_RMII_BIT] | rmii_strap;
  wire next_powerdown_en = !exp[EXP_PWRDN_DIS_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Access sequencer
  // A request is taken only when idle; one raised during an access is dropped
  always_comb begin
    next_state = ST_IDLE;
    case (state)
      ST_IDLE: begin
        if (!req_i) begin
          next_state = ST_IDLE;
        end else if (we_i) begin
          next_state = ST_WRITE;
        end else begin
          next_state = ST_READ;
        end
      end
      ST_READ: next_state = ST_IDLE;
      ST_WRITE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Ack trails the access state by one flop so that it comes from a register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= do_rd || do_wr;
    end
  end

  // Read data holds until the next read, so a slow requester may take it late
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 16'h0000;
    end else if (do_rd) begin
      rdata_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ovr <= OVR_RESET;
    end else if (wr_ovr) begin
      ovr <= ovr_wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      exp <= EXP_RESET;
    end else if (wr_exp) begin
      exp <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_en <= IRQ_EN_RESET;
    end else if (wr_irq) begin
      irq_en <= irq_en_wdata;
    end
  end

  // Straps are caught on the first clocked edge after reset release; a strap
  // that moves later has no effect until the next reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strap_taken <= 1'b0;
      addr_strap <= 2'b00;
      rmii_strap <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      addr_strap <= phy_address_strap_i;
      rmii_strap <= rmii_strap_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      back_to_back_o <= 1'b0;
      pin_chain_test_o <= 1'b0;
      rmii_mode_o <= 1'b1;
      energy_detect_powerdown_en_o <= 1'b0;
      mgmt_phy_addr_o <= PHY_ADDR_LOW;
    end else begin
      back_to_back_o <= next_back_to_back;
      pin_chain_test_o <= next_pin_chain_test;
      rmii_mode_o <= next_rmii_mode;
      energy_detect_powerdown_en_o <= next_powerdown_en;
      mgmt_phy_addr_o <= strap_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flags
  pmsr_irq_flags #(
    .N(IRQ_NUM)
  ) u_flags (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .event_i(irq_event_i),
    .rd_clear_i(rd_clear),
    .enable_i(irq_en),
    .flags_o(flags),
    .irq_o(irq_o)
  );
endmodule

// *** pmsr_pkg.sv ***
package pmsr_pkg;
  // Register addresses (5-bit management register space)
  localparam logic [4:0] ADDR_OPMODE_OVR = 5'h16;
  localparam logic [4:0] ADDR_OPMODE_STAT = 5'h17;
  localparam logic [4:0] ADDR_EXP_CTRL = 5'h18;
  localparam logic [4:0] ADDR_IRQ_CTRL_STAT = 5'h1b;
  // Override register fields
  localparam int OVR_B2B_BIT = 6;
  localparam int OVR_NAND_BIT = 5;
  localparam int OVR_RMII_BIT = 1;
  localparam logic [15:0] OVR_RESET = 16'h0002;
  localparam logic [15:0] OVR_RW_MASK = 16'h007f;
  // Strap status fields
  localparam int STAT_ADDR_LSB = 13;
  localparam int STAT_RMII_BIT = 1;
  // Expanded control
  localparam int EXP_PWRDN_DIS_BIT = 11;
  localparam logic [15:0] EXP_RESET = 16'h0801;
  // Interrupt control/status
  localparam int IRQ_EN_LSB = 8;
  localparam int IRQ_NUM = 8;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  // Management addresses selectable by strap
  localparam logic [4:0] PHY_ADDR_LOW = 5'h00;
  localparam logic [4:0] PHY_ADDR_HIGH = 5'h03;
  // Access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } pmsr_state_t;
endpackage

// *** pmsr_irq_flags.sv ***
`timescale 1ns/1ps
module pmsr_irq_flags
  import pmsr_pkg::*;
#(
  parameter int N = IRQ_NUM
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Events and read-clear
  input wire logic [N-1:0] event_i,
  input wire logic rd_clear_i,
  input wire logic [N-1:0] enable_i,
  // Status
  output logic [N-1:0] flags_o,
  output logic irq_o
);
  logic [N-1:0] next_flags;

  // A fresh event wins over the clear caused by a read
  assign next_flags = rd_clear_i ? event_i : (flags_o | event_i);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags_o <= '0;
      irq_o <= 1'b0;
    end else begin
      flags_o <= next_flags;
      irq_o <= |(next_flags & enable_i);
    end
  end
endmodule

// *** pmsr_mgmt_model.sv ***
`timescale 1ns/1ps
module pmsr_mgmt_model import pmsr_pkg::*; (
  // Access port toward the register bank
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [15:0] rdata_i,
  output logic req_o,
  output logic we_o,
  output logic [4:0] addr_o,
  output logic [15:0] wdata_o
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 16'h0000;
  end
  // Request lasts one cycle; address and data stay until the cycle after ack
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    q = 16'hxxxx;
    @(negedge clk_i);
    we_o = w;
    addr_o = a;
    wdata_o = (w && a == ADDR_OPMODE_OVR && d[OVR_B2B_BIT]) ?
              (d | (16'h0001 << OVR_RMII_BIT)) : d;
    req_o = 1'b1;
    @(negedge clk_i);
    req_o = 1'b0;
    for (int n = 0; n < 6 && ack_i !== 1'b1; n++) @(negedge clk_i);
    if (ack_i === 1'b1) q = rdata_i;
    @(negedge clk_i);
    addr_o = ~a;
    wdata_o = ~wdata_o;
  endtask
endmodule

// *** pmsr_regs_assertions.sv ***
`timescale 1ns/1ps
module pmsr_regs_assertions import pmsr_pkg::*; (
  // Observed ports
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0] phy_address_strap_i,
  input wire logic rmii_strap_i,
  input wire logic we_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic ack_o,
  input wire logic [15:0] rdata_o,
  input wire logic [7:0] irq_event_i,
  input wire logic back_to_back_o,
  input wire logic pin_chain_test_o,
  input wire logic rmii_mode_o,
  input wire logic energy_detect_powerdown_en_o,
  input wire logic [4:0] mgmt_phy_addr_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire logic wr_ovr = ack_o && we_i && addr_i == ADDR_OPMODE_OVR;
  wire logic rd_irq = ack_o && !we_i && addr_i == ADDR_IRQ_CTRL_STAT;
  property p_b2b; wr_ovr |=> back_to_back_o == $past(wdata_i[OVR_B2B_BIT]); endproperty
  a_b2b: assert property (p_b2b) else $error("b2b wrong");
  property p_pin; wr_ovr |=> pin_chain_test_o == $past(wdata_i[OVR_NAND_BIT]); endproperty
  a_pin: assert property (p_pin) else $error("pin chain wrong");
  property p_rmii; wr_ovr && wdata_i[OVR_RMII_BIT] |=> rmii_mode_o; endproperty
  a_rmii: assert property (p_rmii) else $error("rmii wrong");
  property p_powerdown; ack_o && we_i && addr_i == ADDR_EXP_CTRL
    |=> energy_detect_powerdown_en_o != $past(wdata_i[EXP_PWRDN_DIS_BIT]); endproperty
  a_powerdown: assert property (p_powerdown) else $error("powerdown wrong");
  property p_strap; ack_o && !we_i && addr_i == ADDR_OPMODE_STAT
    |-> rdata_o[14:13] == phy_address_strap_i && rdata_o[1] == rmii_strap_i; endproperty
  a_strap: assert property (p_strap) else $error("strap status wrong");
  property p_addr; !$past(srst_i) && !$past(srst_i, 2)
    |-> mgmt_phy_addr_o == (phy_address_strap_i[1] ? PHY_ADDR_HIGH : PHY_ADDR_LOW); endproperty
  a_addr: assert property (p_addr) else $error("phy address wrong");
  property p_irq_on; $rose(irq_o)
    |-> $past(irq_event_i) != 8'h00 || $past(we_i && addr_i == ADDR_IRQ_CTRL_STAT); endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq without cause");
  property p_irq_rd; rd_irq && irq_event_i == 8'h00 && $past(irq_event_i) == 8'h00
    && $past(irq_event_i, 2) == 8'h00 |=> !irq_o; endproperty
  a_irq_rd: assert property (p_irq_rd) else $error("flags not cleared");
endmodule
bind pmsr_regs pmsr_regs_assertions u_chk (.clk_i, .srst_i, .phy_address_strap_i,
  .rmii_strap_i, .we_i, .addr_i, .wdata_i, .ack_o, .rdata_o, .irq_event_i, .back_to_back_o,
  .pin_chain_test_o, .rmii_mode_o, .energy_detect_powerdown_en_o, .mgmt_phy_addr_o, .irq_o);

// *** test_phy_mode_strap_irq_regs.sv ***
`timescale 1ns/1ps
module test_phy_mode_strap_irq_regs import pmsr_pkg::*;;
  logic clk_i = 1'b0, srst_i = 1'b1, rmii_strap_i = 1'b0, req_i, we_i, ack_o;
  logic b2b, pt, rm, ed, irq_o;
  logic [1:0] phy_address_strap_i = 2'h0;
  logic [7:0] irq_event_i = 8'h00, en;
  logic [4:0] addr_i, mgmt_phy_addr_o;
  logic [15:0] wdata_i, rdata_o, q, d;
  int errors = 0, total_checks = 0, seed = 36869;
  initial forever #2 clk_i = ~clk_i;
  pmsr_regs u_dut (.clk_i, .srst_i, .phy_address_strap_i, .rmii_strap_i, .req_i, .we_i,
    .addr_i, .wdata_i, .ack_o, .rdata_o, .irq_event_i, .back_to_back_o(b2b),
    .pin_chain_test_o(pt), .rmii_mode_o(rm), .energy_detect_powerdown_en_o(ed),
    .mgmt_phy_addr_o, .irq_o);
  pmsr_mgmt_model u_mgmt (.clk_i, .ack_i(ack_o), .rdata_i(rdata_o), .req_o(req_i),
    .we_o(we_i), .addr_o(addr_i), .wdata_o(wdata_i));
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] e, input string n);
    u_mgmt.xfer(1'b0, a, 16'h0000, q);
    check(n, q, e);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] stat(input logic [1:0] s, input logic r);
    return {1'b0, s, 11'h000, r, 1'b0};
  endfunction
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      srst_i = 1'b1;
      phy_address_strap_i = i[1:0];
      rmii_strap_i = i[0];
      repeat (4) @(negedge clk_i);
      srst_i = 1'b0;
      rc(ADDR_OPMODE_OVR, OVR_RESET, "ovr reset");
      rc(ADDR_EXP_CTRL, EXP_RESET, "exp reset");
      rc(ADDR_IRQ_CTRL_STAT, 16'h0000, "irq reset");
      check("phy addr", mgmt_phy_addr_o, i[1] ? PHY_ADDR_HIGH : PHY_ADDR_LOW);
      check("reset modes", {12'h000, b2b, pt, rm, ed}, 16'h0002);
      u_mgmt.xfer(1'b1, ADDR_OPMODE_STAT, 16'hffff, q);
      u_mgmt.xfer(1'b1, 5'h1f, 16'hffff, q);
      rc(5'h1f, 16'h0000, "unmapped");
      rc(ADDR_OPMODE_STAT, stat(i[1:0], i[0]), "strap");
      d = 16'($random(seed));
      d[OVR_B2B_BIT] = i[0] ^ i[1];
      d[OVR_RMII_BIT] = d[OVR_RMII_BIT] | d[OVR_B2B_BIT];
      u_mgmt.xfer(1'b1, ADDR_OPMODE_OVR, d, q);
      rc(ADDR_OPMODE_OVR, d & OVR_RW_MASK, "ovr");
      check("b2b", b2b, d[OVR_B2B_BIT]);
      check("pin chain", pt, d[OVR_NAND_BIT]);
      check("rmii", rm, d[OVR_RMII_BIT] | i[0]);
      d = 16'($random(seed));
      u_mgmt.xfer(1'b1, ADDR_EXP_CTRL, d, q);
      rc(ADDR_EXP_CTRL, d, "exp");
      check("powerdown", ed, !d[EXP_PWRDN_DIS_BIT]);
      $display("strap case %0d done", i);
    end
    // Each event alone, with a random enable set, so gated and ungated cases both occur
    for (int b = 0; b < 8; b++) begin
      en = 8'($random(seed));
      u_mgmt.xfer(1'b1, ADDR_IRQ_CTRL_STAT, {en, 8'hff}, q);
      @(negedge clk_i);
      irq_event_i = 8'h01 << b;
      @(negedge clk_i);
      irq_event_i = 8'h00;
      @(negedge clk_i);
      check("irq", irq_o, en[b]);
      rc(ADDR_IRQ_CTRL_STAT, {en, 8'h01 << b}, "irq status");
      check("irq after read", irq_o, 1'b0);
    end
    // An event landing on the clearing edge of a status read must survive it
    fork
      u_mgmt.xfer(1'b0, ADDR_IRQ_CTRL_STAT, 16'h0000, q);
      begin
        repeat (2) @(negedge clk_i);
        irq_event_i = 8'h80;
        @(negedge clk_i);
        irq_event_i = 8'h00;
      end
    join
    check("irq collide", {8'h00, q[7:0]}, 16'h0000);
    rc(ADDR_IRQ_CTRL_STAT, {en, 8'h80}, "irq kept");
    $display("interrupt tests done");
    conclude;
  end
  initial begin
    #40000;
    errors++;
    conclude;
  end
endmodule
